// *** core/fcs_pkg.sv ***
package fcs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CLK_DIV = 16'h1820;
    localparam logic [15:0] IDX_STATUS = 16'h1825;
    localparam logic [15:0] IDX_COMMAND = 16'h1826;
    localparam logic [15:0] IDX_ADDR_HI = 16'h1827;
    localparam logic [15:0] IDX_ADDR_LO = 16'h1828;
    localparam logic [15:0] IDX_DATA = 16'h1829;
    localparam int ADDR_W = 18;

    // Status register field positions
    localparam int BIT_CBEF = 7;
    localparam int BIT_CCF = 6;
    localparam int BIT_PVIOL = 5;
    localparam int BIT_ACCERR = 4;
    localparam int BIT_BLANK = 2;

    // Reset values
    localparam logic [7:0] RST_STATUS = 8'hc0;
    localparam logic [7:0] RST_COMMAND = 8'h00;

    // Command codes
    localparam logic [6:0] CMD_BLANK = 7'h05;
    localparam logic [6:0] CMD_BYTE_PROG = 7'h20;
    localparam logic [6:0] CMD_BURST_PROG = 7'h25;
    localparam logic [6:0] CMD_PAGE_ERASE = 7'h40;
    localparam logic [6:0] CMD_MASS_ERASE = 7'h41;

    // Command write sequence, one-hot
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_DATA = 3'b010,
        SEQ_CMD = 3'b100
    } fcs_seq_t;

    // Request handed to the array
    typedef struct packed {
        logic [6:0] cmd;
        logic [15:0] addr;
        logic [7:0] data;
    } fcs_arr_req_t;
endpackage

// *** core/fcs_unit.sv ***
// Operation
// RQ1: Writing 1 to buffer-empty launches and clears it; buffer transfer refills it.
// RQ2: Only burst program may be buffered behind a running burst program.
// RQ3: With buffer-empty at 0 no further command is accepted.
// RQ4: Complete flag sets when idle and empty; clears on launch.
// RQ5: Writes to the complete flag change nothing.
// RQ6: Launch targeting a protected location sets protect flag, command discarded.
// RQ7: Protect flag clears only by writing 1 to it.
// RQ8: Wrong command write sequence sets access error, command ignored.
// RQ9: Program or erase before divider written sets access error.
// RQ10: Stop mode during a running command sets access error.
// RQ11: Access error clears on write of 1; write of 0 does nothing.
// RQ12: Blank check end sets blank flag only when array is all erased.
// RQ13: Blank flag clears on valid launch; writes to it do nothing.
// RQ14: Decoder accepts blank check, byte program, burst program and two erases.
// RQ15: Code 0x40 erases one 512-byte page, 0x41 the whole array.
// RQ16: Any other code is illegal and sets access error.
// RQ17: Software needs blank check only for unlocking security.
// RQ18: Status bits 3, 1, 0 read zero; writes ignored.
// RQ19: Protected locations are never programmed or erased.
// RQ20: Software writes address, data, command, then launches; else access error. The code checks only the data, command, launch order.
// RQ21: Command register reads zero and resets to zero.
`timescale 1ns/100ps
module fcs_unit (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [17:0] av_address_in,
    input wire logic av_read_in,
    input wire logic av_write_in,
    input wire logic [31:0] av_writedata_in,
    input wire logic [3:0] av_byteenable_in,
    output logic [31:0] av_readdata_out,
    output logic av_waitrequest_out,
    input wire logic [6:0] prot_sel_in,
    input wire logic prot_disable_in,
    input wire logic stop_mode_in,
    input wire logic array_done_in,
    input wire logic array_blank_in,
    output logic array_start_out,
    output fcs_pkg::fcs_arr_req_t array_req_out
);
    // Byte address of a register index
    function automatic logic [17:0] reg_addr(input logic [15:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    // The five accepted command codes
    function automatic logic legal_code(input logic [6:0] c);
        legal_code = (c == fcs_pkg::CMD_BLANK) ||
            (c == fcs_pkg::CMD_BYTE_PROG) ||
            (c == fcs_pkg::CMD_BURST_PROG) ||
            (c == fcs_pkg::CMD_PAGE_ERASE) ||
            (c == fcs_pkg::CMD_MASS_ERASE);
    endfunction

    // Protected pages lie above the select value; mass erase hits any
    function automatic logic is_protected(input logic [6:0] c,
                                          input logic [15:0] a,
                                          input logic [6:0] sel,
                                          input logic dis);
        if (dis || c == fcs_pkg::CMD_BLANK) begin
            is_protected = 1'b0;
        end else if (c == fcs_pkg::CMD_MASS_ERASE) begin
            is_protected = 1'b1;
        end else begin
            is_protected = (a[15:9] > sel);
        end
    endfunction

    logic cbef_r, cbef_nxt, ccf_r, ccf_nxt, pviol_r, pviol_nxt;
    logic accerr_r, accerr_nxt, blank_r, blank_nxt;
    logic exec_r, exec_nxt, pend_r, pend_nxt, div_ok_r, div_ok_nxt;
    logic wait_r, wait_nxt, start_r, start_nxt;
    logic [6:0] cmd_r, cmd_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [7:0] data_r, data_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    fcs_pkg::fcs_seq_t seq_r, seq_nxt;
    fcs_pkg::fcs_arr_req_t pend_req_r, pend_req_nxt;
    fcs_pkg::fcs_arr_req_t arr_r, arr_nxt;
    logic do_wr, launch_try, launch_ok, acc_set, pv_set;
    logic [7:0] wd, status_val;

    // Status as read; bits 3, 1, 0 are constant zero
    assign status_val = {cbef_r, ccf_r, pviol_r, accerr_r,
                         1'b0, blank_r, 2'b00}; // see RQ18
    assign wd = av_writedata_in[7:0];
    assign do_wr = av_write_in && !wait_r && av_byteenable_in[0];

    // Next state of bus slave, command sequencer and status flags
    always_comb begin
        cbef_nxt = cbef_r;
        pviol_nxt = pviol_r;
        accerr_nxt = accerr_r;
        blank_nxt = blank_r;
        exec_nxt = exec_r;
        pend_nxt = pend_r;
        div_ok_nxt = div_ok_r;
        cmd_nxt = cmd_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        seq_nxt = seq_r;
        pend_req_nxt = pend_req_r;
        arr_nxt = arr_r;
        rdata_nxt = rdata_r;
        start_nxt = 1'b0;
        wait_nxt = 1'b1;
        launch_try = 1'b0;
        launch_ok = 1'b0;
        acc_set = 1'b0;
        pv_set = 1'b0;
        // One wait cycle, then the answer stands for one edge
        if ((av_read_in || av_write_in) && wait_r) begin
            wait_nxt = 1'b0;
            if (av_read_in) begin
                rdata_nxt = 32'h0000_0000;
                if (av_address_in == reg_addr(fcs_pkg::IDX_STATUS)) begin
                    rdata_nxt[7:0] = status_val;
                end else if (av_address_in ==
                             reg_addr(fcs_pkg::IDX_CLK_DIV)) begin
                    rdata_nxt[0] = div_ok_r;
                end else if (av_address_in ==
                             reg_addr(fcs_pkg::IDX_ADDR_HI)) begin
                    rdata_nxt[7:0] = addr_r[15:8];
                end else if (av_address_in ==
                             reg_addr(fcs_pkg::IDX_ADDR_LO)) begin
                    rdata_nxt[7:0] = addr_r[7:0];
                end else if (av_address_in ==
                             reg_addr(fcs_pkg::IDX_DATA)) begin
                    rdata_nxt[7:0] = data_r;
                end // Command and unmapped read zero, see RQ21
            end
        end
        // Array finished the running command
        if (exec_r && array_done_in) begin
            exec_nxt = 1'b0;
            if (arr_r.cmd == fcs_pkg::CMD_BLANK) begin
                blank_nxt = array_blank_in; // see RQ12
            end
        end
        // Buffered command moves to the array when it is free
        if (pend_r && !exec_r) begin
            pend_nxt = 1'b0;
            exec_nxt = 1'b1;
            arr_nxt = pend_req_r;
            start_nxt = 1'b1;
            cbef_nxt = 1'b1; // see RQ1
        end
        if (stop_mode_in && exec_r) begin
            acc_set = 1'b1; // see RQ10
        end
        // Register writes
        if (do_wr) begin
            if (av_address_in == reg_addr(fcs_pkg::IDX_STATUS)) begin
                // Complete and blank bits are not writable, see RQ5 RQ13
                if (wd[fcs_pkg::BIT_PVIOL]) begin
                    pviol_nxt = 1'b0; // see RQ7
                end
                if (wd[fcs_pkg::BIT_ACCERR]) begin
                    accerr_nxt = 1'b0; // see RQ11
                end
                if (wd[fcs_pkg::BIT_CBEF] && cbef_r) begin
                    launch_try = 1'b1;
                    seq_nxt = fcs_pkg::SEQ_IDLE;
                    if (seq_r != fcs_pkg::SEQ_CMD) begin
                        acc_set = 1'b1; // see RQ8 RQ20
                    end else if (!legal_code(cmd_r)) begin
                        acc_set = 1'b1; // see RQ14 RQ15 RQ16
                    end else if (cmd_r != fcs_pkg::CMD_BLANK &&
                                 !div_ok_r) begin
                        acc_set = 1'b1; // see RQ9
                    end else if (is_protected(cmd_r, addr_r, prot_sel_in,
                                              prot_disable_in)) begin
                        pv_set = 1'b1; // see RQ6 RQ19
                    end else if (exec_r && !(cmd_r == fcs_pkg::CMD_BURST_PROG
                                 && arr_r.cmd == fcs_pkg::CMD_BURST_PROG))
                    begin
                        acc_set = 1'b1; // see RQ2
                    end else begin
                        launch_ok = 1'b1;
                        cbef_nxt = 1'b0; // see RQ1
                        blank_nxt = 1'b0; // see RQ13
                        pend_nxt = 1'b1;
                        pend_req_nxt = '{cmd: cmd_r, addr: addr_r,
                                         data: data_r};
                    end
                end
            end else if (av_address_in == reg_addr(fcs_pkg::IDX_CLK_DIV))
            begin
                div_ok_nxt = 1'b1;
            end else if (!cbef_r) begin
                // Buffer full: any sequence write is refused, see RQ3
                if (av_address_in == reg_addr(fcs_pkg::IDX_COMMAND) ||
                    av_address_in == reg_addr(fcs_pkg::IDX_DATA) ||
                    av_address_in == reg_addr(fcs_pkg::IDX_ADDR_HI) ||
                    av_address_in == reg_addr(fcs_pkg::IDX_ADDR_LO)) begin
                    acc_set = 1'b1;
                end
            end else if (av_address_in == reg_addr(fcs_pkg::IDX_ADDR_HI))
            begin
                addr_nxt[15:8] = wd;
            end else if (av_address_in == reg_addr(fcs_pkg::IDX_ADDR_LO))
            begin
                addr_nxt[7:0] = wd;
            end else if (av_address_in == reg_addr(fcs_pkg::IDX_DATA)) begin
                if (seq_r == fcs_pkg::SEQ_CMD) begin
                    acc_set = 1'b1; // see RQ8 RQ20
                    seq_nxt = fcs_pkg::SEQ_IDLE;
                end else begin
                    data_nxt = wd;
                    seq_nxt = fcs_pkg::SEQ_DATA;
                end
            end else if (av_address_in == reg_addr(fcs_pkg::IDX_COMMAND))
            begin
                if (seq_r != fcs_pkg::SEQ_DATA) begin
                    acc_set = 1'b1; // see RQ8 RQ20
                    seq_nxt = fcs_pkg::SEQ_IDLE;
                end else begin
                    cmd_nxt = wd[6:0];
                    seq_nxt = fcs_pkg::SEQ_CMD;
                end
            end
        end
        // Hardware set wins over a software clear in the same cycle
        if (acc_set) begin
            accerr_nxt = 1'b1;
        end
        if (pv_set) begin
            pviol_nxt = 1'b1;
        end
        ccf_nxt = cbef_nxt && !exec_nxt && !pend_nxt; // see RQ4
    end

    // Register all state
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cbef_r <= fcs_pkg::RST_STATUS[fcs_pkg::BIT_CBEF];
            ccf_r <= fcs_pkg::RST_STATUS[fcs_pkg::BIT_CCF];
            pviol_r <= fcs_pkg::RST_STATUS[fcs_pkg::BIT_PVIOL];
            accerr_r <= fcs_pkg::RST_STATUS[fcs_pkg::BIT_ACCERR];
            blank_r <= fcs_pkg::RST_STATUS[fcs_pkg::BIT_BLANK];
            exec_r <= 1'b0;
            pend_r <= 1'b0;
            div_ok_r <= 1'b0;
            cmd_r <= fcs_pkg::RST_COMMAND[6:0]; // see RQ21
            addr_r <= 16'h0000;
            data_r <= 8'h00;
            seq_r <= fcs_pkg::SEQ_IDLE;
            pend_req_r <= '0;
            arr_r <= '0;
            rdata_r <= 32'h0000_0000;
            wait_r <= 1'b1;
            start_r <= 1'b0;
        end else begin
            cbef_r <= cbef_nxt;
            ccf_r <= ccf_nxt;
            pviol_r <= pviol_nxt;
            accerr_r <= accerr_nxt;
            blank_r <= blank_nxt;
            exec_r <= exec_nxt;
            pend_r <= pend_nxt;
            div_ok_r <= div_ok_nxt;
            cmd_r <= cmd_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            seq_r <= seq_nxt;
            pend_req_r <= pend_req_nxt;
            arr_r <= arr_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            start_r <= start_nxt;
        end
    end

    // Outputs straight from flops
    assign av_readdata_out = rdata_r;
    assign av_waitrequest_out = wait_r;
    assign array_start_out = start_r;
    assign array_req_out = arr_r;

    // Checks
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    chk_launch_flags: assert property ( // see RQ1 RQ4 RQ13
        launch_ok |=> !cbef_r && !ccf_r && !blank_r ##1 cbef_r || exec_r)
        else $error("launch did not clear flags");
    chk_burst_only: assert property ( // see RQ2
        launch_ok && exec_r |-> cmd_r == fcs_pkg::CMD_BURST_PROG)
        else $error("non-burst command buffered");
    chk_full_refuse: assert property ( // see RQ3
        !cbef_r && do_wr && av_address_in == reg_addr(fcs_pkg::IDX_DATA)
        |=> accerr_r && $stable(data_r))
        else $error("write accepted while buffer full");
    chk_ccf_meaning: assert property ( // see RQ4 RQ5
        ccf_r |-> cbef_r && !exec_r && !pend_r)
        else $error("complete flag set while busy");
    chk_pviol_sticky: assert property ( // see RQ7
        pviol_r && !(do_wr && wd[fcs_pkg::BIT_PVIOL] &&
        av_address_in == reg_addr(fcs_pkg::IDX_STATUS)) |=> pviol_r)
        else $error("protect flag dropped without write");
    chk_illegal_code: assert property ( // see RQ16
        launch_try && seq_r == fcs_pkg::SEQ_CMD && !legal_code(cmd_r)
        |=> accerr_r && cbef_r && !start_r)
        else $error("illegal code not refused");
    chk_protect_drop: assert property ( // see RQ6 RQ19
        pv_set |=> pviol_r && cbef_r ##1 !start_r)
        else $error("protected command not discarded");
    chk_stop_error: assert property ( // see RQ10
        stop_mode_in && exec_r |=> accerr_r)
        else $error("stop during command not flagged");
    chk_div_first: assert property ( // see RQ9
        launch_ok && cmd_r != fcs_pkg::CMD_BLANK |-> div_ok_r)
        else $error("program before divider written");
    chk_cmd_zero: assert property ( // see RQ21
        av_read_in && wait_r &&
        av_address_in == reg_addr(fcs_pkg::IDX_COMMAND)
        |=> av_readdata_out == 32'h0000_0000 && !av_waitrequest_out)
        else $error("command register read not zero");
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [17:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = '0;
    logic [3:0] be = 4'h1;
    logic [31:0] rdat;
    logic wreq;
    logic [6:0] psel = 7'h10;
    logic pdis = 1'b1;
    logic stop = 1'b0;
    logic done = 1'b0;
    logic blank = 1'b0;
    logic start;
    fcs_pkg::fcs_arr_req_t req;
    fcs_pkg::fcs_arr_req_t got_q[$];
    fcs_pkg::fcs_arr_req_t exp_q[$];
    int failures = 0;
    int checked = 0;
    int seq = 0;
    logic [31:0] rng = 32'h50;
    logic cbef = 1'b1;
    logic ccf = 1'b1;
    logic pv = 1'b0;
    logic ae = 1'b0;
    logic bk = 1'b0;
    logic divw = 1'b0;
    logic busy = 1'b0;
    logic bufd = 1'b0;
    logic [6:0] mcmd = '0;
    logic [6:0] run = '0;
    logic [15:0] mad = '0;
    logic [7:0] mdat = '0;
    fcs_pkg::fcs_arr_req_t mpend = '0;
    logic [6:0] ills[5] = '{7'h00, 7'h7f, 7'h21, 7'h42, 7'h06};
    logic [6:0] oks[5];

    fcs_unit dut (.mclk_in(clk), .rst_n_in(rst_n), .av_address_in(adr),
        .av_read_in(rd), .av_write_in(wr), .av_writedata_in(wd),
        .av_byteenable_in(be), .av_readdata_out(rdat),
        .av_waitrequest_out(wreq), .prot_sel_in(psel),
        .prot_disable_in(pdis), .stop_mode_in(stop), .array_done_in(done),
        .array_blank_in(blank), .array_start_out(start),
        .array_req_out(req));

    // Clock and start-pulse monitor
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (start === 1'b1) begin
            got_q.push_back(req);
        end
    end

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task automatic check(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One Avalon access; holds the request until waitrequest is low
    task automatic bus(input logic w, input logic [15:0] idx,
        input logic [7:0] d, output logic [31:0] q);
        logic [31:0] r;
        int n;
        r = rnd();
        n = 0;
        @(posedge clk);
        adr <= {idx, 2'b00};
        wd <= {r[31:8], d};
        rd <= !w;
        wr <= w;
        // Waitrequest and read data are taken at the rising edge
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 50);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic err();
        ae = 1'b1;
        seq = 0;
    endtask

    // Model of a status write: flag clears, then launch checks
    task automatic launch(input logic [7:0] d);
        if (d[5]) pv = 1'b0;
        if (d[4]) ae = 1'b0;
        if (d[7] && cbef) begin
            if (seq != 2 || !(mcmd inside {oks})) ae = 1'b1;
            else if (!divw && mcmd != fcs_pkg::CMD_BLANK) ae = 1'b1;
            else if (!pdis && mcmd != fcs_pkg::CMD_BLANK &&
                (mcmd == fcs_pkg::CMD_MASS_ERASE || mad[15:9] > psel))
                pv = 1'b1;
            else if (busy && (mcmd != fcs_pkg::CMD_BURST_PROG ||
                run != fcs_pkg::CMD_BURST_PROG)) ae = 1'b1;
            else begin
                bk = 1'b0;
                ccf = 1'b0;
                // A buffered burst reaches the array only when it is free
                if (busy) {bufd, cbef, mpend} = {2'b10, mcmd, mad, mdat};
                else begin
                    {busy, run} = {1'b1, mcmd};
                    exp_q.push_back({mcmd, mad, mdat});
                end
            end
            seq = 0;
        end
    endtask

    // Register write, then the model follows it
    task automatic wr8(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
        if (be[0] !== 1'b1) return;
        if (idx == fcs_pkg::IDX_CLK_DIV) divw = 1'b1;
        else if (idx == fcs_pkg::IDX_STATUS) launch(d);
        else if (idx < fcs_pkg::IDX_COMMAND || idx > fcs_pkg::IDX_DATA);
        else if (!cbef) err();
        else if (idx == fcs_pkg::IDX_ADDR_HI) mad[15:8] = d;
        else if (idx == fcs_pkg::IDX_ADDR_LO) mad[7:0] = d;
        else if (idx == fcs_pkg::IDX_DATA && seq == 2) err();
        else if (idx == fcs_pkg::IDX_DATA) {mdat, seq} = {d, 32'd1};
        else if (seq != 1) err();
        else {mcmd, seq} = {d[6:0], 32'd2};
    endtask

    task automatic st(input logic [7:0] d);
        wr8(fcs_pkg::IDX_STATUS, d);
    endtask

    task automatic rd8(input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        check("read data", {24'h0, e}, q);
    endtask

    // Status against the model, then array requests seen so far
    task automatic cks();
        repeat (2) @(posedge clk);
        rd8(fcs_pkg::IDX_STATUS, {cbef, ccf, pv, ae, 1'b0, bk, 2'b00});
        check("starts", 32'(exp_q.size()), 32'(got_q.size()));
        while (got_q.size() > 0 && exp_q.size() > 0)
            check("request", 32'(exp_q.pop_front()), 32'(got_q.pop_front()));
        exp_q.delete();
        got_q.delete();
    endtask

    task automatic go(input logic [6:0] c, input logic [7:0] hi);
        logic [31:0] r;
        r = rnd();
        wr8(fcs_pkg::IDX_ADDR_HI, hi);
        wr8(fcs_pkg::IDX_ADDR_LO, r[7:0]);
        wr8(fcs_pkg::IDX_DATA, r[15:8]);
        wr8(fcs_pkg::IDX_COMMAND, {1'b0, c});
        st(8'h80);
    endtask

    // Array completion pulse with a blank-check result
    task automatic fin(input logic b);
        @(posedge clk);
        done <= 1'b1;
        blank <= b;
        @(posedge clk);
        done <= 1'b0;
        if (busy && run == fcs_pkg::CMD_BLANK) bk = b;
        if (bufd) begin
            {bufd, cbef} = 2'b01;
            exp_q.push_back(mpend);
        end else {busy, ccf} = 2'b01;
    endtask

    task automatic stop_pulse();
        @(posedge clk);
        stop <= 1'b1;
        @(posedge clk);
        stop <= 1'b0;
        if (busy) ae = 1'b1;
    endtask

    // Watchdog well above the expected run length
    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    initial begin
        oks = '{fcs_pkg::CMD_BLANK, fcs_pkg::CMD_BYTE_PROG,
            fcs_pkg::CMD_BURST_PROG, fcs_pkg::CMD_PAGE_ERASE,
            fcs_pkg::CMD_MASS_ERASE};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cks();
        rd8(fcs_pkg::IDX_COMMAND, 8'h00);
        wr8(16'h1830, 8'hff);
        rd8(16'h1830, 8'h00);
        $display("test reset done");
        go(fcs_pkg::CMD_BYTE_PROG, 8'h00);
        cks();
        st(8'h00);
        cks();
        st(8'h10);
        go(fcs_pkg::CMD_BLANK, 8'h00);
        fin(1'b1);
        cks();
        st(8'h4f);
        cks();
        $display("test divider done");
        wr8(fcs_pkg::IDX_CLK_DIV, 8'h13);
        for (int i = 0; i < 5; i++) begin
            go(oks[i], 8'(rnd()));
            cks();
            fin(rng[3]);
            cks();
        end
        // Mass erase ran last and no blank check follows it
        $display("test codes done");
        foreach (ills[i]) begin
            go(ills[i], 8'h00);
            cks();
            st(8'h10);
        end
        $display("test illegal done");
        wr8(fcs_pkg::IDX_COMMAND, 8'h20);
        cks();
        st(8'h10);
        wr8(fcs_pkg::IDX_DATA, 8'h5a);
        wr8(fcs_pkg::IDX_COMMAND, 8'h20);
        wr8(fcs_pkg::IDX_DATA, 8'h5a);
        st(8'h80);
        cks();
        st(8'h10);
        $display("test sequence done");
        pdis <= 1'b0;
        go(fcs_pkg::CMD_PAGE_ERASE, 8'hfe);
        cks();
        go(fcs_pkg::CMD_MASS_ERASE, 8'h00);
        st(8'h40);
        cks();
        go(fcs_pkg::CMD_BYTE_PROG, 8'h20);
        fin(1'b0);
        st(8'h20);
        cks();
        pdis <= 1'b1;
        $display("test protection done");
        go(fcs_pkg::CMD_BURST_PROG, 8'(rnd()));
        go(fcs_pkg::CMD_BURST_PROG, 8'(rnd()));
        cks();
        wr8(fcs_pkg::IDX_ADDR_HI, 8'h00);
        wr8(fcs_pkg::IDX_DATA, 8'h00);
        cks();
        st(8'h90);
        fin(1'b0);
        cks();
        go(fcs_pkg::CMD_BYTE_PROG, 8'h00);
        cks();
        fin(1'b0);
        st(8'h10);
        cks();
        $display("test burst done");
        stop_pulse();
        go(fcs_pkg::CMD_PAGE_ERASE, 8'h00);
        stop_pulse();
        cks();
        fin(1'b0);
        be <= 4'he;
        st(8'h10);
        be <= 4'h1;
        cks();
        $display("test stop done");
        wrap_up();
    end
endmodule
